// File: src/srcc_pkg.sv
/*
 * Package for the start-up reset and clock-configuration block: register map,
 * field layouts, reset values, ratio codes and lock-wait timing.
 * Assumes a 32-bit classic Wishbone register bus and one 200 MHz clock.
 */
package srcc_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] PWR_MGMT_ADDR = 4'h0;
   localparam logic [3:0] RRCTL_ADDR    = 4'h4;
   localparam logic [3:0] STATUS_ADDR   = 4'h8;

   // ----------------------------------------
   // Field layouts and reset values
   // ----------------------------------------
   localparam int MULT_W = 6;
   localparam int DIV_W  = 2;
   localparam int MULT_LSB = 0;
   localparam int DIV_LSB  = 8;
   localparam int RRCTL_EN_BIT = 0;
   localparam logic [DIV_W-1:0] DIV_RESET = 2'h0;

   // ----------------------------------------
   // Clock-ratio codes and resulting multipliers
   // ----------------------------------------
   localparam logic [1:0] RATIO_8  = 2'h0;
   localparam logic [1:0] RATIO_32 = 2'h1;
   localparam logic [1:0] RATIO_16 = 2'h2;
   localparam logic [MULT_W-1:0] MULT_8  = 6'h08;
   localparam logic [MULT_W-1:0] MULT_16 = 6'h10;
   localparam logic [MULT_W-1:0] MULT_32 = 6'h20;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int LOCK_CYCLES = 4096;
   localparam int CNT_W = 13;

   typedef enum {ST_RESET, ST_LOCK, ST_RUN} srcc_state_t;

   typedef struct packed {
      logic [MULT_W-1:0] mult;
      logic [DIV_W-1:0]  div;
   } srcc_pll_cfg_t;

endpackage

// File: src/srcc_top.sv
/*
 * Start-up reset and clock-configuration logic of a signal processor core.
 * Samples the ratio and boot-mode straps at reset release, waits for the PLL
 * lock count, then releases the core to the reset vector. Registers over
 * classic Wishbone. Assumes straps are stable before reset release.
 */
// Behaviour
// - Ratio pins 00 give 8:1, 01 give 32:1, 10 give 16:1; 11 reserved
// - Once the core runs, software may change PLL multiplier/divider; writes during lock wait are ignored
// - After hardware reset release, wait 4096 reference cycles for lock
// - After the lock wait, core fetches from the reset vector
// - Hardware reset returns the sequencer, core reset and control bit to a known state
// - Shared reset pin defaults to a reset output showing reset state
// - Control bit 0 turns the shared pin into a running-reset input
// - Boot mode is taken from the boot-mode select pins
`timescale 1ns/100ps
`default_nettype none
module srcc_top #(
   parameter int LOCK_CYCLES = srcc_pkg::LOCK_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Board pins
   input  wire logic        hw_reset_n_i,
   input  wire logic [1:0]  clk_ratio_sel_i,
   input  wire logic [2:0]  boot_mode_sel_i,
   input  wire logic        reset_pin_i,
   output logic             reset_pin_o,
   output logic             reset_pin_oe_n_o,
   // Core side
   output logic             core_reset_o,
   output logic             core_fetch_vector_o,
   output logic [2:0]       boot_mode_o,
   output logic [5:0]       pll_mult_o,
   output logic [1:0]       pll_div_o,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);

   localparam logic [srcc_pkg::CNT_W-1:0] LOCK_LAST = srcc_pkg::CNT_W'(LOCK_CYCLES - 1);

   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   srcc_pkg::srcc_state_t          state_reg, state_next;
   logic [srcc_pkg::CNT_W-1:0]     cnt_reg, cnt_next;
   logic                           core_reset_reg, core_reset_next;
   logic                           fetch_reg, fetch_next;
   logic [2:0]                     boot_reg, boot_next;
   srcc_pkg::srcc_pll_cfg_t        pll_reg, pll_next;
   logic                           rr_en_reg, rr_en_next;
   logic                           pin_o_reg, pin_o_next;
   logic                           pin_oe_n_reg, pin_oe_n_next;
   logic [31:0]                    dat_reg, dat_next;
   logic                           ack_reg, ack_next;
   logic                           wb_req, wr_pwr_mgmt, wr_rrctl;
   logic                           run_reset;
   logic [srcc_pkg::MULT_W-1:0]    strap_mult;

   // Unknown address or reserved strap simply fall back to defaults
   always_comb begin
      unique case (clk_ratio_sel_i)
         srcc_pkg::RATIO_8:  strap_mult = srcc_pkg::MULT_8;
         srcc_pkg::RATIO_32: strap_mult = srcc_pkg::MULT_32;
         srcc_pkg::RATIO_16: strap_mult = srcc_pkg::MULT_16;
         default:            strap_mult = srcc_pkg::MULT_8;
      endcase
   end

   assign wb_req   = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr_pwr_mgmt = wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == srcc_pkg::PWR_MGMT_ADDR;
   assign wr_rrctl = wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == srcc_pkg::RRCTL_ADDR;
   // Running reset only counts once the core is up, and only when selected
   assign run_reset = rr_en_reg && !reset_pin_i && state_reg == srcc_pkg::ST_RUN;

   // ----------------------------------------
   // Sequencer next state
   // ----------------------------------------
   always_comb begin
      state_next      = state_reg;
      cnt_next        = cnt_reg;
      core_reset_next = core_reset_reg;
      fetch_next      = 1'b0;
      boot_next       = boot_reg;
      pll_next        = pll_reg;
      unique case (state_reg)
         srcc_pkg::ST_RESET: begin
            core_reset_next = 1'b1;
            if (hw_reset_n_i) begin
               boot_next     = boot_mode_sel_i;
               pll_next.mult = strap_mult;
               pll_next.div  = srcc_pkg::DIV_RESET;
               cnt_next      = '0;
               state_next    = srcc_pkg::ST_LOCK;
            end
         end
         srcc_pkg::ST_LOCK: begin
            if (cnt_reg == LOCK_LAST) begin
               core_reset_next = 1'b0;
               fetch_next      = 1'b1;
               state_next      = srcc_pkg::ST_RUN;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         srcc_pkg::ST_RUN: begin
            if (wr_pwr_mgmt) begin
               pll_next.mult = wb_dat_i[srcc_pkg::MULT_LSB +: srcc_pkg::MULT_W];
               pll_next.div  = wb_dat_i[srcc_pkg::DIV_LSB +: srcc_pkg::DIV_W];
            end
            if (run_reset) begin
               core_reset_next = 1'b1;
               cnt_next        = '0;
               state_next      = srcc_pkg::ST_LOCK;
            end
         end
      endcase
      if (!hw_reset_n_i) begin
         core_reset_next = 1'b1;
         fetch_next      = 1'b0;
         state_next      = srcc_pkg::ST_RESET;
      end
   end

   // ----------------------------------------
   // Shared pin and control register
   // ----------------------------------------
   always_comb begin
      rr_en_next = rr_en_reg;
      if (wr_rrctl) begin
         rr_en_next = wb_dat_i[srcc_pkg::RRCTL_EN_BIT];
      end
      if (!hw_reset_n_i) begin
         rr_en_next = 1'b0;
      end
      // Pin drives low-active reset state unless running-reset input selected
      pin_oe_n_next = rr_en_next;
      pin_o_next    = !core_reset_next;
   end

   // ----------------------------------------
   // Wishbone slave: one wait state, unmapped reads return zero
   // ----------------------------------------
   always_comb begin
      ack_next = wb_req;
      dat_next = '0;
      if (wb_req && !wb_we_i) begin
         unique case (wb_adr_i)
            srcc_pkg::PWR_MGMT_ADDR: begin
               dat_next[srcc_pkg::MULT_LSB +: srcc_pkg::MULT_W] = pll_reg.mult;
               dat_next[srcc_pkg::DIV_LSB +: srcc_pkg::DIV_W]   = pll_reg.div;
            end
            srcc_pkg::RRCTL_ADDR:  dat_next[srcc_pkg::RRCTL_EN_BIT] = rr_en_reg;
            srcc_pkg::STATUS_ADDR: dat_next[4:0] = {boot_reg, reset_pin_i, core_reset_reg};
            default:               dat_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg      <= srcc_pkg::ST_RESET;
         cnt_reg        <= '0;
         core_reset_reg <= 1'b1;
         fetch_reg      <= 1'b0;
         boot_reg       <= '0;
         pll_reg        <= '{mult: srcc_pkg::MULT_8, div: srcc_pkg::DIV_RESET};
      end else begin
         state_reg      <= state_next;
         cnt_reg        <= cnt_next;
         core_reset_reg <= core_reset_next;
         fetch_reg      <= fetch_next;
         boot_reg       <= boot_next;
         pll_reg        <= pll_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rr_en_reg      <= 1'b0;
         pin_o_reg      <= 1'b0;
         pin_oe_n_reg   <= 1'b0;
      end else begin
         rr_en_reg      <= rr_en_next;
         pin_o_reg      <= pin_o_next;
         pin_oe_n_reg   <= pin_oe_n_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_reg        <= '0;
         ack_reg        <= 1'b0;
      end else begin
         dat_reg        <= dat_next;
         ack_reg        <= ack_next;
      end
   end

   assign core_reset_o        = core_reset_reg;
   assign core_fetch_vector_o = fetch_reg;
   assign boot_mode_o         = boot_reg;
   assign pll_mult_o          = pll_reg.mult;
   assign pll_div_o           = pll_reg.div;
   assign reset_pin_o         = pin_o_reg;
   assign reset_pin_oe_n_o    = pin_oe_n_reg;
   assign wb_dat_o            = dat_reg;
   assign wb_ack_o            = ack_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_release;
      state_reg == srcc_pkg::ST_RESET && hw_reset_n_i;
   endsequence
   sequence s_locked;
      !core_reset_reg && fetch_reg;
   endsequence

   property p_lock_wait;
      @(posedge clk_i) disable iff (rst_i || !hw_reset_n_i)
      s_release |=> core_reset_reg [*8];
   endproperty
   a_lock_wait: assert property (p_lock_wait) else $error("Core left reset too early");

   property p_fetch_follows;
      @(posedge clk_i) disable iff (rst_i)
      $fell(core_reset_reg) |-> s_locked;
   endproperty
   a_fetch_follows: assert property (p_fetch_follows) else $error("No vector fetch on release");

   property p_hw_reset;
      @(posedge clk_i) disable iff (rst_i)
      !hw_reset_n_i |=> core_reset_reg && state_reg == srcc_pkg::ST_RESET && !rr_en_reg;
   endproperty
   a_hw_reset: assert property (p_hw_reset) else $error("Hardware reset not honoured");

   property p_ratio;
      @(posedge clk_i) disable iff (rst_i)
      (s_release and (clk_ratio_sel_i == srcc_pkg::RATIO_32)) |=> pll_reg.mult == srcc_pkg::MULT_32;
   endproperty
   a_ratio: assert property (p_ratio) else $error("Ratio strap misdecoded");

   property p_boot;
      @(posedge clk_i) disable iff (rst_i)
      s_release |=> boot_reg == $past(boot_mode_sel_i);
   endproperty
   a_boot: assert property (p_boot) else $error("Boot mode not latched");

   property p_pin_out;
      @(posedge clk_i) disable iff (rst_i)
      !pin_oe_n_reg |-> pin_o_reg == !core_reset_reg;
   endproperty
   a_pin_out: assert property (p_pin_out) else $error("Reset output wrong");

   property p_pin_in;
      @(posedge clk_i) disable iff (rst_i)
      wr_rrctl && wb_dat_i[0] && hw_reset_n_i |=> pin_oe_n_reg;
   endproperty
   a_pin_in: assert property (p_pin_in) else $error("Pin not released to input");

   property p_pwr_mgmt;
      @(posedge clk_i) disable iff (rst_i)
      wr_pwr_mgmt && state_reg == srcc_pkg::ST_RUN && hw_reset_n_i
         |=> pll_reg.mult == $past(wb_dat_i[5:0]);
   endproperty
   a_pwr_mgmt: assert property (p_pwr_mgmt) else $error("PLL write lost");

   // PLL settings must not move while the core is still held for lock
   property p_lock_refuse;
      @(posedge clk_i) disable iff (rst_i)
      wr_pwr_mgmt && state_reg == srcc_pkg::ST_LOCK |=> $stable(pll_reg);
   endproperty
   a_lock_refuse: assert property (p_lock_refuse) else $error("PLL changed during lock");

   property p_ratio_16;
      @(posedge clk_i) disable iff (rst_i)
      (s_release and (clk_ratio_sel_i == srcc_pkg::RATIO_16)) |=> pll_reg.mult == srcc_pkg::MULT_16;
   endproperty
   a_ratio_16: assert property (p_ratio_16) else $error("Ratio strap 16 misdecoded");

   property p_ratio_8;
      @(posedge clk_i) disable iff (rst_i)
      (s_release and (clk_ratio_sel_i == srcc_pkg::RATIO_8))
         |=> pll_reg.mult == srcc_pkg::MULT_8 && pll_reg.div == srcc_pkg::DIV_RESET;
   endproperty
   a_ratio_8: assert property (p_ratio_8) else $error("Ratio strap 8 misdecoded");

   sequence s_relock;
      core_reset_reg && state_reg == srcc_pkg::ST_LOCK && cnt_reg == '0;
   endsequence

   property p_run_reset;
      @(posedge clk_i) disable iff (rst_i)
      run_reset && hw_reset_n_i |=> s_relock;
   endproperty
   a_run_reset: assert property (p_run_reset) else $error("Running reset not taken");

   property p_lock_held;
      @(posedge clk_i) disable iff (rst_i)
      state_reg == srcc_pkg::ST_LOCK |-> core_reset_reg && !pin_o_reg;
   endproperty
   a_lock_held: assert property (p_lock_held) else $error("Reset released during lock");

   property p_fetch_pulse;
      @(posedge clk_i) disable iff (rst_i)
      fetch_reg |=> !fetch_reg;
   endproperty
   a_fetch_pulse: assert property (p_fetch_pulse) else $error("Vector fetch longer than one cycle");

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      ack_reg |=> !ack_reg;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("Bus acknowledge held too long");

endmodule
`default_nettype wire

// File: verif/srcc_board.sv
/*
 * Board model: reset source, strap pins and the pull-up on the shared pin.
 * Assumes the bench makes the reference clock and commands the reset.
 */
`timescale 1ns/100ps
`default_nettype none
module srcc_board (
   // Bench control
   input  wire logic       clk_i,
   input  wire logic       por_i,
   input  wire logic [1:0] ratio_i,
   input  wire logic [2:0] boot_i,
   input  wire logic       pull_i,
   // Device pins
   input  wire logic       pin_drv_i,
   input  wire logic       pin_oe_n_i,
   output logic            hw_reset_n_o,
   output logic [1:0]      ratio_o,
   output logic [2:0]      boot_o,
   output logic            pin_o
);
   logic [1:0] ratio_reg;
   logic [2:0] boot_reg;
   assign hw_reset_n_o = !por_i;
   // Straps follow the bench only while reset is held
   assign ratio_o = por_i ? ratio_i : ratio_reg;
   assign boot_o  = por_i ? boot_i : boot_reg;
   always_ff @(posedge clk_i) begin
      ratio_reg <= ratio_o;
      boot_reg  <= boot_o;
   end
   // Pull-up holds the pin high unless someone pulls it low
   assign pin_o = !pin_oe_n_i ? pin_drv_i : !pull_i;
endmodule
`default_nettype wire

// File: verif/startup_reset_clock_config_bench.sv
/*
 * Self-checking bench for the start-up reset and clock-configuration block.
 * Assumes the board model file and a short lock count in simulation.
 */
`timescale 1ns/100ps
`default_nettype none
module startup_reset_clock_config_bench;
   localparam int LOCK = 8;
   logic clk_i = 1'b0, rst_i = 1'b1, por = 1'b1, pull = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [1:0] ratio = 2'h0, rsel, div;
   logic [2:0] boot = 3'h0, bsel, boot_o, b;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000, rdat, rd, v;
   logic [5:0] mult;
   logic hw_n, pin, pin_o, oe_n, core_rst, fetch, ack;
   int fails = 0, cmp_count = 0, seed = 12, cnt = 0, t0;
   int exp_mult [4] = '{8, 32, 16, 8};
   srcc_top #(.LOCK_CYCLES(LOCK)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .hw_reset_n_i(hw_n),
      .clk_ratio_sel_i(rsel), .boot_mode_sel_i(bsel), .reset_pin_i(pin), .reset_pin_o(pin_o),
      .reset_pin_oe_n_o(oe_n), .core_reset_o(core_rst), .core_fetch_vector_o(fetch),
      .boot_mode_o(boot_o), .pll_mult_o(mult), .pll_div_o(div), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack));
   srcc_board i_board (.clk_i(clk_i), .por_i(por), .ratio_i(ratio), .boot_i(boot), .pull_i(pull),
      .pin_drv_i(pin_o), .pin_oe_n_i(oe_n), .hw_reset_n_o(hw_n), .ratio_o(rsel), .boot_o(bsel),
      .pin_o(pin));
   // Free-running reference clock, never halted
   initial forever #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cnt <= cnt + 1;
      if (cnt == 3000) begin
         $display("mismatch at %0t: run timed out", $time);
         fails = fails + 1;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
      // Only the acknowledge or the bench timeout ends a wait for the answer
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   // Hardware reset with the given ratio strap and a random boot strap, then lock wait with a refused write
   task automatic boot_up(input logic [1:0] r);
      @(posedge clk_i);
      b = 3'($random(seed));
      por <= 1'b1; ratio <= r; boot <= b;
      repeat (3) @(posedge clk_i);
      por <= 1'b0; t0 = cnt;
      ratio <= ~r; boot <= ~b;
      #1 chk(pin_o, 0);
      wb(1'b1, srcc_pkg::PWR_MGMT_ADDR, 32'h0000_003f, 4'hf);
      do begin
         @(posedge clk_i);
         #1;
      end while (core_rst === 1'b1 && cnt - t0 < 40);
      chk(cnt - t0, LOCK + 2);
      chk(fetch, 1);
      chk(mult, exp_mult[r]);
      chk(boot_o, b);
      chk({pin_o, oe_n}, 2'b10);
      @(posedge clk_i);
      #1 chk(fetch, 0);
   endtask
   task automatic final_report();
      $display("compares %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) boot_up(2'(i));
      $display("test straps and lock done");
      for (int i = 0; i < 3; i++) begin
         v = $random(seed);
         wb(1'b1, srcc_pkg::PWR_MGMT_ADDR, v, 4'hf);
         wb(1'b1, srcc_pkg::PWR_MGMT_ADDR, ~v, 4'h0);
         chk({div, mult}, {v[9:8], v[5:0]});
      end
      wb(1'b1, 4'hc, 32'hffff_ffff, 4'hf);
      wb(1'b0, 4'hc, 32'h0000_0000, 4'hf);
      chk(rd, 0);
      wb(1'b0, srcc_pkg::STATUS_ADDR, 32'h0000_0000, 4'hf);
      chk(rd, {27'h0, b, 2'b10});
      $display("test registers done");
      wb(1'b1, srcc_pkg::RRCTL_ADDR, 32'h0000_0001, 4'hf);
      #1 chk(oe_n, 1);
      @(posedge clk_i);
      pull <= 1'b1;
      @(posedge clk_i);
      pull <= 1'b0; t0 = cnt;
      #1 chk(core_rst, 1);
      do begin
         @(posedge clk_i);
         #1;
      end while (core_rst === 1'b1 && cnt - t0 < 40);
      chk(cnt - t0, LOCK + 1);
      boot_up(2'h2);
      $display("test running reset done");
      final_report();
   end
endmodule
`default_nettype wire
